// *** logic/sfc_pkg.sv ***
// sfc_pkg: opcodes, reset values, lane codes and the controller register map
// assumes: both ends run on one 250 MHz sys_clk
package sfc_pkg;
	localparam int CLK_PERIOD_NS = 4;

	typedef enum logic [1:0] {SFC_EXT, SFC_DUAL, SFC_QUAD} sfc_lane_t;

	localparam logic [7:0] OP_WREN   = 8'h06;
	localparam logic [7:0] OP_WRDI   = 8'h04;
	localparam logic [7:0] OP_CLRFS  = 8'h50;
	localparam logic [7:0] OP_RDSR   = 8'h05;
	localparam logic [7:0] OP_RDFS   = 8'h70;
	localparam logic [7:0] OP_RDNV   = 8'hB5;
	localparam logic [7:0] OP_RDVC   = 8'h85;
	localparam logic [7:0] OP_RDEV   = 8'h65;
	localparam logic [7:0] OP_WRSR   = 8'h01;
	localparam logic [7:0] OP_WRNV   = 8'hB1;
	localparam logic [7:0] OP_WRVC   = 8'h81;
	localparam logic [7:0] OP_WREV   = 8'h61;
	localparam logic [7:0] OP_READ   = 8'h03;
	localparam logic [7:0] OP_FRD    = 8'h0B;
	localparam logic [7:0] OP_DOFR   = 8'h3B;
	localparam logic [7:0] OP_DIOFR  = 8'hBB;
	localparam logic [7:0] OP_QOFR   = 8'h6B;
	localparam logic [7:0] OP_QIOFR  = 8'hEB;
	localparam logic [7:0] OP_QIOWR  = 8'hE7;
	localparam logic [7:0] OP_DTRFR  = 8'h0D;
	localparam logic [7:0] OP_DTRDO  = 8'h3D;
	localparam logic [7:0] OP_DTRDIO = 8'hBD;
	localparam logic [7:0] OP_DTRQO  = 8'h6D;
	localparam logic [7:0] OP_DTRQIO = 8'hED;

	localparam logic [15:0] NVCR_RST  = 16'hFFFF;
	localparam logic [15:0] NVCR_RSVD = 16'h0010;
	localparam logic [7:0]  VCR_RST   = 8'hFF;
	localparam logic [7:0]  VCR_RSVD  = 8'h04;
	localparam logic [7:0]  EVCR_RST  = 8'hFF;
	localparam logic [7:0]  EVCR_RSVD = 8'h10;
	localparam logic [4:0]  OPC_BITS  = 5'd8;
	localparam logic [4:0]  BYTE_BITS = 5'd8;
	localparam logic [4:0]  NVCR_BITS = 5'd16;
	localparam logic [4:0]  ADDR_BITS = 5'd24;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_GO   = 8'h04;
	localparam logic [7:0] REG_ADDR = 8'h08;
	localparam logic [7:0] REG_TXD  = 8'h0C;
	localparam logic [7:0] REG_RXD  = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam int CTL_PROTO = 0;
	localparam int CTL_DLANE = 2;
	localparam int CTL_ADDR  = 4;
	localparam int CTL_DTR   = 5;
	localparam int CTL_WPLOW = 6;
	localparam int CTL_DUM   = 8;
	localparam int CTL_TXN   = 12;
	localparam int CTL_RXN   = 16;
	localparam int CTL_OP    = 24;
	localparam logic [3:0] HOST_QTR_CYC = 4'd3;

	function automatic logic [4:0] lane_w(logic [1:0] c);
		case (c)
			2'd1:    lane_w = 5'd2;
			2'd2:    lane_w = 5'd4;
			default: lane_w = 5'd1;
		endcase
	endfunction
endpackage

// *** logic/sfc_link_if.sv ***
// sfc_link_if: serial flash link between controller and flash device
// assumes: lanes have a pull-up, so an undriven lane reads high
`timescale 1ns/100ps
interface sfc_link_if;
	logic       sck;
	logic       cs_n;
	logic       wp_n;
	logic [3:0] h_dq_o;
	logic [3:0] h_dq_oe;
	logic [3:0] d_dq_o;
	logic [3:0] d_dq_oe;
	logic [3:0] dq;

	assign dq = (h_dq_oe & h_dq_o) | (d_dq_oe & d_dq_o) | ~(h_dq_oe | d_dq_oe);

	modport host (output sck, cs_n, wp_n, h_dq_o, h_dq_oe, input dq);
	modport dev  (input sck, cs_n, wp_n, dq, output d_dq_o, d_dq_oe);
endinterface

// *** logic/sfc_sync.sv ***
// sfc_sync: two flip-flop synchroniser for a bundle of pins
// assumes: each bit is independent; no bus coherency is implied
`timescale 1ns/100ps
module sfc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sfc_sync_t;

	sfc_sync_t s_ff;
	sfc_sync_t nxt_s;

	always_comb begin
		nxt_s.s1 = d;
		nxt_s.s2 = s_ff.s1;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q = s_ff.s2;
endmodule

// *** logic/sfc_dev.sv ***
// sfc_dev: flash end; decodes register commands and read memory headers
// assumes: link pins are asynchronous and sampled by sys_clk, link clock
// slower than a sixth of sys_clk; the array itself sits on mem_addr/mem_data
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/100ps
// Summary of operation
// R1 - write enable opcode sets the latch
// R2 - write disable clears latch unless protection error
// R3 - enable/disable need select raised after opcode
// R4 - opcode lanes follow extended, dual, quad
// R5 - extended reads: input lane 0, output lane 1
// R6 - status reads always accepted, repeat while clocked
// R7 - host checks busy before other commands
// R8 - nonvolatile read: low byte first, then zeros
// R9 - volatile reads repeat the same byte
// R10 - host sends write enable before register writes
// R11 - writes execute only on exact final bit
// R12 - status write changes bits seven to two
// R13 - protection bit combines with write protect pin
// R14 - self-timed writes: busy, latch cleared, busy drops
// R15 - status and nonvolatile writes have own durations
// R16 - host sends nonvolatile data low byte first
// R17 - volatile writes immediate, reserved bits kept
// R18 - address follows opcode at command lane width
// R19 - double rate reads take address on both edges
// R20 - three byte address, output auto increments, wraps
// R21 - busy device ignores all but status reads
module sfc_dev #(
	parameter int W_TIME_NS    = 2000,
	parameter int NVCR_TIME_NS = 4000,
	parameter int DUMMY_CLKS   = 8
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	sfc_link_if.dev          lnk,
	input  wire logic [1:0]  proto_mode,
	input  wire logic [7:0]  mem_data,
	output logic      [23:0] mem_addr,
	output logic             wel,
	output logic             busy
);
	localparam int W_CYC  = (W_TIME_NS + sfc_pkg::CLK_PERIOD_NS - 1) / sfc_pkg::CLK_PERIOD_NS;
	localparam int NV_CYC = (NVCR_TIME_NS + sfc_pkg::CLK_PERIOD_NS - 1) / sfc_pkg::CLK_PERIOD_NS;

	typedef enum logic [2:0] {D_OP, D_CMD, D_WIN, D_ADR, D_DUM, D_OUT, D_IGN} sfc_dst_t;
	typedef struct packed {
		sfc_dst_t    st;
		logic        cs_p;
		logic        sck_p;
		logic [4:0]  cnt;
		logic [23:0] sh;
		logic [7:0]  op;
		logic [1:0]  alane;
		logic [1:0]  olane;
		logic        dtr;
		logic [3:0]  dum;
		logic [7:0]  osh;
		logic [3:0]  obits;
		logic [1:0]  nvidx;
		logic [5:0]  prot;
		logic        wel;
		logic        busy;
		logic        perr;
		logic [15:0] tmr;
		logic [15:0] nvcr;
		logic [7:0]  vcr;
		logic [7:0]  evcr;
		logic [23:0] maddr;
		logic [3:0]  dq_o;
		logic [3:0]  dq_oe;
	} sfc_dev_t;

	sfc_dev_t    s_ff;
	sfc_dev_t    nxt_s;
	logic [6:0]  pins;
	logic        cs;
	logic        rise;
	logic        fall;
	logic [1:0]  lane;
	logic [4:0]  w;
	logic [23:0] nsh;
	logic [4:0]  cnt_n;
	logic [4:0]  need;
	logic [7:0]  src;
	logic [7:0]  ob;

	// extended protocol keeps per-command lane widths; dual and quad use all
	function automatic logic [1:0] lane_of(logic [7:0] op, logic [1:0] p, logic adr);
		lane_of = 2'd0;
		if (p != 2'd0) begin
			lane_of = p;
		end else begin
			case (op)
				sfc_pkg::OP_DIOFR, sfc_pkg::OP_DTRDIO:                   lane_of = 2'd1;
				sfc_pkg::OP_QIOFR, sfc_pkg::OP_QIOWR, sfc_pkg::OP_DTRQIO: lane_of = 2'd2;
				sfc_pkg::OP_DOFR, sfc_pkg::OP_DTRDO: lane_of = adr ? 2'd0 : 2'd1;
				sfc_pkg::OP_QOFR, sfc_pkg::OP_DTRQO: lane_of = adr ? 2'd0 : 2'd2;
				default:                                                 lane_of = 2'd0;
			endcase
		end
	endfunction

	function automatic logic [23:0] shin(logic [23:0] v, logic [3:0] d, logic [1:0] c);
		case (c)
			2'd1:    shin = {v[21:0], d[1:0]};
			2'd2:    shin = {v[19:0], d};
			default: shin = {v[22:0], d[0]}; // see R5
		endcase
	endfunction

	sfc_sync #(.WIDTH(7)) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d       ({lnk.cs_n, lnk.sck, lnk.wp_n, lnk.dq}),
		.q       (pins)
	);

	assign cs    = pins[6];
	assign rise  = pins[5] & ~s_ff.sck_p & ~cs;
	assign fall  = ~pins[5] & s_ff.sck_p & ~cs;
	assign lane  = (s_ff.st == D_ADR) ? s_ff.alane : ((s_ff.st == D_OUT) ? s_ff.olane : proto_mode);
	assign w     = sfc_pkg::lane_w(lane);
	assign nsh   = shin(s_ff.sh, pins[3:0], lane);
	assign cnt_n = s_ff.cnt + w;
	assign need  = (s_ff.op == sfc_pkg::OP_WRNV) ? sfc_pkg::NVCR_BITS : sfc_pkg::BYTE_BITS;

	always_comb begin
		case (s_ff.op)
			sfc_pkg::OP_RDSR: src = {s_ff.prot, s_ff.wel, s_ff.busy};
			sfc_pkg::OP_RDFS: src = {~s_ff.busy, 5'h00, s_ff.perr, 1'b0};
			sfc_pkg::OP_RDNV: begin // see R8
				if (s_ff.nvidx == 2'd0) begin
					src = s_ff.nvcr[7:0] | sfc_pkg::NVCR_RSVD[7:0];
				end else if (s_ff.nvidx == 2'd1) begin
					src = s_ff.nvcr[15:8] | sfc_pkg::NVCR_RSVD[15:8];
				end else begin
					src = 8'h00;
				end
			end
			sfc_pkg::OP_RDVC: src = s_ff.vcr; // see R9
			sfc_pkg::OP_RDEV: src = s_ff.evcr; // see R9
			default:          src = mem_data;
		endcase
	end

	always_comb begin
		nxt_s       = s_ff;
		ob          = (s_ff.obits == 4'd0) ? src : s_ff.osh;
		nxt_s.cs_p  = cs;
		nxt_s.sck_p = pins[5];
		if (s_ff.busy) begin // see R15
			if (s_ff.tmr == 16'h0000) begin
				nxt_s.busy = 1'b0; // see R14
			end else begin
				nxt_s.tmr = s_ff.tmr - 16'h0001;
			end
		end
		if (cs) begin
			nxt_s.st    = D_OP;
			nxt_s.cnt   = 5'd0;
			nxt_s.obits = 4'd0;
			nxt_s.dq_oe = 4'h0;
			if (s_ff.cs_p) begin
				// nothing executes unless select rose on the exact last bit
			end else if (s_ff.st == D_CMD) begin // see R3
				case (s_ff.op)
					sfc_pkg::OP_WREN: nxt_s.wel = 1'b1; // see R1
					sfc_pkg::OP_WRDI: nxt_s.wel = s_ff.perr & s_ff.wel; // see R2
					sfc_pkg::OP_CLRFS: begin
						nxt_s.perr = 1'b0; // see R2
						nxt_s.wel  = 1'b0;
					end
					default: nxt_s.wel = s_ff.wel;
				endcase
			end else if (s_ff.st == D_WIN && s_ff.cnt == need && s_ff.wel) begin // see R11
				case (s_ff.op)
					sfc_pkg::OP_WRSR: begin
						if (s_ff.prot[5] && !pins[4]) begin
							nxt_s.perr = 1'b1; // see R13
						end else begin
							nxt_s.prot = s_ff.sh[7:2]; // see R12
							nxt_s.wel  = 1'b0; // see R14
							nxt_s.busy = 1'b1;
							nxt_s.tmr  = 16'(W_CYC - 1);
						end
					end
					sfc_pkg::OP_WRNV: begin
						nxt_s.nvcr = {s_ff.sh[7:0], s_ff.sh[15:8]};
						nxt_s.wel  = 1'b0; // see R14
						nxt_s.busy = 1'b1;
						nxt_s.tmr  = 16'(NV_CYC - 1);
					end
					sfc_pkg::OP_WRVC: begin // see R17
						nxt_s.vcr = (s_ff.sh[7:0] & ~sfc_pkg::VCR_RSVD) | (s_ff.vcr & sfc_pkg::VCR_RSVD);
						nxt_s.wel = 1'b0;
					end
					default: begin // see R17
						nxt_s.evcr = (s_ff.sh[7:0] & ~sfc_pkg::EVCR_RSVD) | (s_ff.evcr & sfc_pkg::EVCR_RSVD);
						nxt_s.wel  = 1'b0;
					end
				endcase
			end
		end else begin
			case (s_ff.st)
				D_OP: if (rise) begin // see R4
					nxt_s.sh  = nsh;
					nxt_s.cnt = cnt_n;
					if (cnt_n == sfc_pkg::OPC_BITS) begin
						nxt_s.op    = nsh[7:0];
						nxt_s.cnt   = 5'd0;
						nxt_s.nvidx = 2'd0;
						nxt_s.alane = lane_of(nsh[7:0], proto_mode, 1'b1); // see R18
						nxt_s.olane = lane_of(nsh[7:0], proto_mode, 1'b0);
						nxt_s.dtr   = nsh[3:0] == 4'hD; // see R19
						if (s_ff.busy && nsh[7:0] != sfc_pkg::OP_RDSR
								&& nsh[7:0] != sfc_pkg::OP_RDFS) begin
							nxt_s.st = D_IGN; // see R21
						end else begin
							case (nsh[7:0])
								sfc_pkg::OP_WREN, sfc_pkg::OP_WRDI, sfc_pkg::OP_CLRFS:
									nxt_s.st = D_CMD;
								sfc_pkg::OP_RDSR, sfc_pkg::OP_RDFS, sfc_pkg::OP_RDNV,
								sfc_pkg::OP_RDVC, sfc_pkg::OP_RDEV:
									nxt_s.st = D_OUT; // see R6
								sfc_pkg::OP_WRSR, sfc_pkg::OP_WRNV, sfc_pkg::OP_WRVC,
								sfc_pkg::OP_WREV:
									nxt_s.st = D_WIN;
								sfc_pkg::OP_READ, sfc_pkg::OP_FRD, sfc_pkg::OP_DOFR,
								sfc_pkg::OP_DIOFR, sfc_pkg::OP_QOFR, sfc_pkg::OP_QIOFR,
								sfc_pkg::OP_QIOWR, sfc_pkg::OP_DTRFR, sfc_pkg::OP_DTRDO,
								sfc_pkg::OP_DTRDIO, sfc_pkg::OP_DTRQO, sfc_pkg::OP_DTRQIO:
									nxt_s.st = D_ADR;
								default: nxt_s.st = D_IGN;
							endcase
						end
					end
				end
				D_CMD: if (rise) begin
					nxt_s.st = D_IGN; // see R3
				end
				D_WIN: if (rise) begin
					nxt_s.sh  = nsh;
					nxt_s.cnt = cnt_n;
					if (cnt_n > need) begin
						nxt_s.st = D_IGN; // see R11
					end
				end
				// the fall that closes the opcode is not an address half
				D_ADR: if (rise || (fall && s_ff.dtr && s_ff.cnt != 5'd0)) begin // see R19
					nxt_s.sh  = nsh;
					nxt_s.cnt = cnt_n;
					if (cnt_n == sfc_pkg::ADDR_BITS) begin // see R20
						nxt_s.maddr = nsh;
						nxt_s.dum   = 4'(DUMMY_CLKS);
						if (s_ff.op == sfc_pkg::OP_READ || DUMMY_CLKS == 0) begin
							nxt_s.st = D_OUT;
						end else begin
							nxt_s.st = D_DUM;
						end
					end
				end
				D_DUM: if (rise) begin
					nxt_s.dum = s_ff.dum - 4'h1;
					if (s_ff.dum == 4'h1) begin
						nxt_s.st = D_OUT;
					end
				end
				D_OUT: if (fall) begin // see R5
					case (lane)
						2'd1: begin
							nxt_s.dq_o  = {2'b00, ob[7:6]};
							nxt_s.dq_oe = 4'h3;
						end
						2'd2: begin
							nxt_s.dq_o  = ob[7:4];
							nxt_s.dq_oe = 4'hF;
						end
						default: begin
							nxt_s.dq_o  = {2'b00, ob[7], 1'b0};
							nxt_s.dq_oe = 4'h2;
						end
					endcase
					nxt_s.osh   = 8'(ob << w);
					nxt_s.obits = ((s_ff.obits == 4'd0) ? 4'd8 : s_ff.obits) - 4'(w);
					if (s_ff.obits == 4'd0) begin
						nxt_s.maddr = s_ff.maddr + 24'h000001; // see R20
						if (s_ff.nvidx != 2'd2) begin
							nxt_s.nvidx = s_ff.nvidx + 2'd1;
						end
					end
				end
				default: nxt_s.st = D_IGN;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_ff      <= '0;
			s_ff.st   <= D_OP;
			s_ff.cs_p <= 1'b1;
			s_ff.nvcr <= sfc_pkg::NVCR_RST;
			s_ff.vcr  <= sfc_pkg::VCR_RST;
			s_ff.evcr <= sfc_pkg::EVCR_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lnk.d_dq_o  = s_ff.dq_o;
	assign lnk.d_dq_oe = s_ff.dq_oe;
	assign mem_addr    = s_ff.maddr;
	assign wel         = s_ff.wel;
	assign busy        = s_ff.busy;
endmodule

// *** logic/sfc_host.sv ***
// sfc_host: serial flash controller; software sets up one command over APB
// assumes: APB runs on sys_clk; the link clock is divided from sys_clk
`timescale 1ns/100ps
module sfc_host (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	sfc_link_if.host         lnk
);
	typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} sfc_hst_t;
	typedef enum logic [2:0] {P_OP, P_AD, P_DM, P_TX, P_RX} sfc_ph_t;
	typedef struct packed {
		sfc_hst_t    st;
		sfc_ph_t     ph;
		logic [3:0]  div;
		logic [1:0]  q;
		logic [5:0]  cnt;
		logic [47:0] sh;
		logic [31:0] rx;
		logic [31:0] ctrl;
		logic [23:0] addr;
		logic [15:0] txd;
		logic        done;
		logic        sck;
		logic        cs_n;
		logic        wp_n;
		logic [3:0]  dq_o;
		logic [3:0]  dq_oe;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} sfc_host_t;

	sfc_host_t  s_ff;
	sfc_host_t  nxt_s;
	logic [3:0] dq_s;
	logic       tick;
	logic [1:0] wc;
	logic [4:0] w;
	sfc_ph_t    np;
	logic       last;

	function automatic logic [5:0] ph_len(sfc_ph_t p, logic [31:0] c);
		case (p)
			P_OP:    ph_len = 6'(sfc_pkg::OPC_BITS);
			P_AD:    ph_len = 6'(sfc_pkg::ADDR_BITS);
			P_DM:    ph_len = {2'b00, c[sfc_pkg::CTL_DUM+:4]};
			P_TX:    ph_len = {c[sfc_pkg::CTL_TXN+:3], 3'b000};
			default: ph_len = {c[sfc_pkg::CTL_RXN+:3], 3'b000};
		endcase
	endfunction

	sfc_sync #(.WIDTH(4)) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d       (lnk.dq),
		.q       (dq_s)
	);

	assign tick = s_ff.div == sfc_pkg::HOST_QTR_CYC - 4'd1;
	assign wc   = (s_ff.ph == P_OP) ? s_ff.ctrl[sfc_pkg::CTL_PROTO+:2] : s_ff.ctrl[sfc_pkg::CTL_DLANE+:2];
	assign w    = sfc_pkg::lane_w(wc);

	// phases that carry no bits are skipped
	always_comb begin
		last = 1'b0;
		np   = P_RX;
		if (s_ff.ph == P_OP && s_ff.ctrl[sfc_pkg::CTL_ADDR]) begin
			np = P_AD;
		end else if (s_ff.ph <= P_AD && s_ff.ctrl[sfc_pkg::CTL_DUM+:4] != 4'h0) begin
			np = P_DM;
		end else if (s_ff.ph <= P_DM && s_ff.ctrl[sfc_pkg::CTL_TXN+:3] != 3'h0) begin
			np = P_TX;
		end else if (s_ff.ph <= P_TX && s_ff.ctrl[sfc_pkg::CTL_RXN+:3] != 3'h0) begin
			np = P_RX;
		end else begin
			last = 1'b1;
		end
	end

	always_comb begin
		nxt_s         = s_ff;
		nxt_s.pready  = 1'b0;
		nxt_s.pslverr = 1'b0;
		if (psel && !penable) begin
			nxt_s.pready = 1'b1;
			case (paddr)
				sfc_pkg::REG_CTRL: nxt_s.prdata = s_ff.ctrl;
				sfc_pkg::REG_GO:   nxt_s.prdata = 32'h00000000;
				sfc_pkg::REG_ADDR: nxt_s.prdata = {8'h00, s_ff.addr};
				sfc_pkg::REG_TXD:  nxt_s.prdata = {16'h0000, s_ff.txd};
				sfc_pkg::REG_RXD:  nxt_s.prdata = s_ff.rx;
				sfc_pkg::REG_STAT: nxt_s.prdata = {30'h00000000, s_ff.done, s_ff.st != H_IDLE};
				default: begin
					nxt_s.prdata  = 32'h00000000;
					nxt_s.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_ff.pready && pwrite) begin
			case (paddr)
				sfc_pkg::REG_CTRL: begin
					nxt_s.ctrl = pwdata;
					nxt_s.wp_n = ~pwdata[sfc_pkg::CTL_WPLOW];
				end
				sfc_pkg::REG_ADDR: nxt_s.addr = pwdata[23:0];
				sfc_pkg::REG_TXD:  nxt_s.txd = pwdata[15:0];
				sfc_pkg::REG_GO: if (pwdata[0] && s_ff.st == H_IDLE) begin
					nxt_s.st   = H_RUN;
					nxt_s.ph   = P_OP;
					nxt_s.cnt  = 6'(sfc_pkg::OPC_BITS);
					nxt_s.q    = 2'd0;
					nxt_s.div  = 4'd0;
					nxt_s.cs_n = 1'b0;
					nxt_s.done = 1'b0;
					nxt_s.rx   = 32'h00000000;
					// nonvolatile data goes low byte first: txd[7:0] leads
					if (s_ff.ctrl[sfc_pkg::CTL_ADDR]) begin // see R16
						nxt_s.sh = {s_ff.ctrl[sfc_pkg::CTL_OP+:8], s_ff.addr,
							s_ff.txd[7:0], s_ff.txd[15:8]};
					end else begin
						nxt_s.sh = {s_ff.ctrl[sfc_pkg::CTL_OP+:8], s_ff.txd[7:0],
							s_ff.txd[15:8], 24'h000000};
					end
				end
				default: nxt_s.ctrl = s_ff.ctrl;
			endcase
		end
		if (s_ff.st != H_IDLE && !(psel && penable && s_ff.pready && pwrite && paddr == sfc_pkg::REG_GO)) begin
			nxt_s.div = tick ? 4'd0 : s_ff.div + 4'd1;
		end
		if (s_ff.st == H_END && tick) begin
			nxt_s.cs_n = 1'b1; // see R3
			if (s_ff.cs_n) begin
				nxt_s.st   = H_IDLE;
				nxt_s.done = 1'b1;
			end
		end
		if (s_ff.st == H_RUN && tick) begin
			nxt_s.q = s_ff.q + 2'd1;
			if ((s_ff.q == 2'd0 && (s_ff.ph == P_OP || s_ff.ph == P_AD || s_ff.ph == P_TX))
					|| (s_ff.q == 2'd2 && s_ff.ph == P_AD && s_ff.ctrl[sfc_pkg::CTL_DTR])) begin
				case (wc) // see R4
					2'd1:    nxt_s.dq_o = {2'b00, s_ff.sh[47:46]};
					2'd2:    nxt_s.dq_o = s_ff.sh[47:44];
					default: nxt_s.dq_o = {3'b000, s_ff.sh[47]};
				endcase
				nxt_s.dq_oe = (wc == 2'd2) ? 4'hF : ((wc == 2'd1) ? 4'h3 : 4'h1);
				nxt_s.sh    = 48'(s_ff.sh << w); // see R18
				nxt_s.cnt   = s_ff.cnt - 6'(w);
			end else if (s_ff.q == 2'd0) begin
				nxt_s.dq_oe = 4'h0;
			end
			if (s_ff.q == 2'd1) begin
				nxt_s.sck = 1'b1;
			end
			if (s_ff.q == 2'd2 && s_ff.ph == P_RX) begin
				case (wc) // see R5
					2'd1:    nxt_s.rx = {s_ff.rx[29:0], dq_s[1:0]};
					2'd2:    nxt_s.rx = {s_ff.rx[27:0], dq_s};
					default: nxt_s.rx = {s_ff.rx[30:0], dq_s[1]};
				endcase
				nxt_s.cnt = s_ff.cnt - 6'(w);
			end
			if (s_ff.q == 2'd3) begin
				nxt_s.sck = 1'b0;
				if (s_ff.ph == P_DM) begin
					nxt_s.cnt = s_ff.cnt - 6'd1;
				end
				if (s_ff.cnt == 6'd0 || (s_ff.ph == P_DM && s_ff.cnt == 6'd1)) begin
					if (last) begin // see R11
						nxt_s.st    = H_END;
						nxt_s.dq_oe = 4'h0;
					end else begin
						nxt_s.ph  = np;
						nxt_s.cnt = ph_len(np, s_ff.ctrl);
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s_ff      <= '0;
			s_ff.st   <= H_IDLE;
			s_ff.cs_n <= 1'b1;
			s_ff.wp_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata      = s_ff.prdata;
	assign pready      = s_ff.pready;
	assign pslverr     = s_ff.pslverr;
	assign lnk.sck     = s_ff.sck;
	assign lnk.cs_n    = s_ff.cs_n;
	assign lnk.wp_n    = s_ff.wp_n;
	assign lnk.h_dq_o  = s_ff.dq_o;
	assign lnk.h_dq_oe = s_ff.dq_oe;
endmodule

// *** verif/sfc_assertions.sv ***
// sfc_assertions: link framing, clock shape and lane ownership checks
// assumes: instantiated beside the link interface, one sys_clk domain
`timescale 1ns/100ps
module sfc_assertions (
	input wire logic       sys_clk,
	input wire logic       rst_n,
	input wire logic       sck,
	input wire logic       cs_n,
	input wire logic [3:0] h_dq_oe,
	input wire logic [3:0] d_dq_o,
	input wire logic [3:0] d_dq_oe
);
	// ----
	// link rules
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_sck_idle; cs_n |-> !sck; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck high while deselected");
	property p_frame_gap; $rose(cs_n) |-> cs_n[*6]; endproperty
	a_frame_gap: assert property (p_frame_gap) else $error("select gap too short");
	property p_sck_high; $rose(sck) |-> sck[*6] ##1 !sck; endproperty
	a_sck_high: assert property (p_sck_high) else $error("sck high phase wrong");
	property p_sck_low; $fell(sck) |-> !sck[*3]; endproperty
	a_sck_low: assert property (p_sck_low) else $error("sck low phase short");
	property p_no_fight; (h_dq_oe & d_dq_oe) == 4'h0; endproperty
	a_no_fight: assert property (p_no_fight) else $error("both ends drive a lane");
	property p_dev_lanes; d_dq_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
	a_dev_lanes: assert property (p_dev_lanes) else $error("device lane set illegal");
	property p_host_lanes; h_dq_oe inside {4'h0, 4'h1, 4'h3, 4'hF}; endproperty
	a_host_lanes: assert property (p_host_lanes) else $error("host lane set illegal");
	property p_dev_release; cs_n[*4] |-> d_dq_oe == 4'h0; endproperty
	a_dev_release: assert property (p_dev_release) else $error("device drives unselected");
	property p_dev_stable; sck && $past(sck) |-> $stable(d_dq_o & d_dq_oe); endproperty
	a_dev_stable: assert property (p_dev_stable) else $error("device output moved");
endmodule

// *** verif/serial_flash_register_commands_tb_top.sv ***
// serial_flash_register_commands_tb_top: host and flash ends joined, driven over APB
// assumes: mem_data is a combinational function of mem_addr
`timescale 1ns/100ps
module serial_flash_register_commands_tb_top;
	localparam int W_NS  = 4000;
	localparam int NV_NS = 8000;
	logic        sys_clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  proto_mode;
	logic [23:0] mem_addr;
	logic        wel;
	logic        busy;
	logic [31:0] rd;
	logic        slv;
	logic [7:0]  wo [2];
	logic [7:0]  ro [2];
	logic [7:0]  rv [2];
	logic [7:0]  rop [5];
	int          rp [5];
	int          rl [5];
	int          rf [5];
	int          failures;
	int          tests_run;
	int          bcnt;
	sfc_link_if u_sfc_link_if ();
	sfc_host u_sfc_host (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lnk(u_sfc_link_if));
	sfc_dev #(.W_TIME_NS(W_NS), .NVCR_TIME_NS(NV_NS)) u_sfc_dev (.sys_clk(sys_clk),
		.rst_n(rst_n), .lnk(u_sfc_link_if), .proto_mode(proto_mode),
		.mem_data(mem_addr[7:0] ^ mem_addr[23:16]), .mem_addr(mem_addr), .wel(wel), .busy(busy));
	sfc_assertions u_sfc_assertions (.sys_clk(sys_clk), .rst_n(rst_n), .sck(u_sfc_link_if.sck),
		.cs_n(u_sfc_link_if.cs_n), .h_dq_oe(u_sfc_link_if.h_dq_oe),
		.d_dq_o(u_sfc_link_if.d_dq_o), .d_dq_oe(u_sfc_link_if.d_dq_oe));
	// ----
	// tasks
	// ----
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) if (busy === 1'b1) bcnt <= bcnt + 1;
	task automatic final_report();
		$display("compares %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic fail();
		failures++;
		final_report();
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) fail();
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	// one whole command: set up, start, poll done, fetch what came back
	task automatic cmd(input logic [7:0] op, input int p, input int l, input int r = 0,
		input int t = 0, input int f = 0, input int dm = 0, input logic [23:0] a = 24'h0,
		input logic [15:0] tx = 16'h0);
		int n;
		n = 0;
		proto_mode <= 2'(p);
		apb(1'b1, sfc_pkg::REG_CTRL, {op, 24'h0} | 32'(r << 16 | t << 12 | dm << 8 | f << 4 | l << 2 | p));
		apb(1'b1, sfc_pkg::REG_ADDR, {8'h00, a});
		apb(1'b1, sfc_pkg::REG_TXD, {16'h0000, tx});
		apb(1'b1, sfc_pkg::REG_GO, 32'h1);
		do begin
			apb(1'b0, sfc_pkg::REG_STAT, 32'h0);
			n++;
		end while (rd[1] !== 1'b1 && n < 600);
		if (rd[1] !== 1'b1) fail();
		apb(1'b0, sfc_pkg::REG_RXD, 32'h0);
	endtask
	task automatic idle();
		int n;
		for (n = 0; n < 5000 && busy !== 1'b0; n++) @(posedge sys_clk);
		if (busy !== 1'b0) fail();
	endtask
	initial begin
		int i;
		logic [23:0] a;
		failures = 0;
		tests_run = 0;
		wo = '{sfc_pkg::OP_WRVC, sfc_pkg::OP_WREV};
		ro = '{sfc_pkg::OP_RDVC, sfc_pkg::OP_RDEV};
		rv = '{sfc_pkg::VCR_RSVD, sfc_pkg::EVCR_RSVD};
		rop = '{sfc_pkg::OP_READ, sfc_pkg::OP_FRD, sfc_pkg::OP_DIOFR, sfc_pkg::OP_QIOFR,
			sfc_pkg::OP_DTRFR};
		rp = '{0, 0, 0, 2, 0};
		rl = '{0, 0, 1, 2, 0};
		rf = '{1, 1, 1, 1, 3};
		{rst_n, psel, penable, pwrite, paddr, pwdata, proto_mode} = '0;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		apb(1'b0, 8'h40, 32'h0);
		chk("pslverr", 32'h1, 32'(slv));
		chk("unmapped", 32'h0, rd);
		cmd(sfc_pkg::OP_RDSR, 0, 0, 1);
		chk("status", 32'h0, rd);
		for (i = 0; i < 3; i++) begin
			cmd(sfc_pkg::OP_WREN, i, i);
			chk("wel", 32'h1, 32'(wel));
			cmd(sfc_pkg::OP_RDSR, i, i, 1);
			chk("status", 32'h2, rd);
			cmd(sfc_pkg::OP_WRDI, i, i);
			chk("wel", 32'h0, 32'(wel));
		end
		cmd(sfc_pkg::OP_WREN, 0, 0, 0, 1, 0, 0, 24'h0, 16'h00FF);
		chk("wel_long", 32'h0, 32'(wel));
		cmd(sfc_pkg::OP_RDNV, 0, 0, 4);
		chk("nvcr", 32'hFFFF_0000, rd);
		for (i = 0; i < 2; i++) begin
			cmd(wo[i], 0, 0, 0, 1);
			cmd(ro[i], 0, 0, 3);
			chk("vol_nowel", 32'h00FF_FFFF, rd);
			cmd(sfc_pkg::OP_WREN, 0, 0);
			cmd(wo[i], 0, 0, 0, 1);
			cmd(ro[i], 0, 0, 2);
			chk("vol", {16'h0, rv[i], rv[i]}, rd);
		end
		cmd(sfc_pkg::OP_WREN, 0, 0);
		cmd(sfc_pkg::OP_WRNV, 0, 0, 0, 1, 0, 0, 24'h0, 16'h1200);
		chk("wel_short", 32'h1, 32'(wel));
		i = bcnt;
		cmd(sfc_pkg::OP_WRNV, 0, 0, 0, 2, 0, 0, 24'h0, 16'h1200);
		idle();
		chk("nv_time", NV_NS / sfc_pkg::CLK_PERIOD_NS, bcnt - i);
		chk("wel", 32'h0, 32'(wel));
		cmd(sfc_pkg::OP_RDNV, 0, 0, 2);
		chk("nvcr", 32'h1012, rd);
		cmd(sfc_pkg::OP_WREN, 0, 0);
		i = bcnt;
		cmd(sfc_pkg::OP_WRSR, 0, 0, 0, 1, 0, 0, 24'h0, 16'h00FF);
		chk("busy", 32'h1, 32'(busy));
		cmd(sfc_pkg::OP_RDFS, 0, 0, 1);
		chk("flags_busy", 32'h0, rd);
		cmd(sfc_pkg::OP_WREN, 0, 0);
		chk("wel_busy", 32'h0, 32'(wel));
		idle();
		chk("sr_time", W_NS / sfc_pkg::CLK_PERIOD_NS, bcnt - i);
		cmd(sfc_pkg::OP_RDSR, 0, 0, 1);
		chk("status", 32'hFC, rd);
		cmd(sfc_pkg::OP_WREN, 0, 0);
		cmd(sfc_pkg::OP_WRSR, 0, 0, 0, 1, 4);
		chk("wel_prot", 32'h1, 32'(wel));
		cmd(sfc_pkg::OP_RDFS, 0, 0, 1);
		chk("flags_prot", 32'h82, rd);
		cmd(sfc_pkg::OP_WRDI, 0, 0);
		chk("wel_wrdi", 32'h1, 32'(wel));
		cmd(sfc_pkg::OP_CLRFS, 0, 0);
		cmd(sfc_pkg::OP_RDFS, 0, 0, 1);
		chk("flags_clr", 32'h80, rd);
		for (i = 0; i < 5; i++) begin
			a = {8'h3C + 8'(i), 8'h5A, 8'(16 * i + 14)};
			cmd(rop[i], rp[i], rl[i], 2, 0, rf[i], (i == 0) ? 0 : 8, a);
			chk("mem", {16'h0, a[7:0] ^ a[23:16], (a[7:0] + 8'h01) ^ a[23:16]}, rd);
		end
		final_report();
	end
endmodule
